// *** hdl/pors_sequencer.sv ***
// Power-on reset, strap capture and host pin routing logic.
`timescale 1ns/1ps
// Function
// - Low on the reset input resets the device; every power-up passes it.
// - Bit 7 of status register 0x000 sets once the device is accessible.
// - Host mode strap picks I2C or SPI host mode at reset.
// - Pins 1 and 0 give the two-bit master clock rate at reset.
// - Pins 5 and 6 have no effect on the reset configuration.
// - After configuration every pin takes a status or control function.
// - Serial clock pin clocks SPI, or is the I2C clock line.
// - Chip select is active low in SPI; address bit 0 in I2C.
module pors_sequencer #(
  parameter int unsigned WINDOW_CYC = pors_pkg::STRAP_WINDOW_CYC
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  input  wire logic [6:0]            gpioIn,
  input  wire logic [6:0]            gpioFunc,
  input  wire logic [6:0]            gpioOutVal,
  input  wire logic                  serialClkIn,
  input  wire logic                  portSelectNAddrBit0In,
  output logic [6:0]                 gpioOut,
  output logic [6:0]                 gpioOe,
  output logic [7:0]                 statusReg,
  output pors_pkg::pors_strap_t      strap,
  output logic                       ready,
  output logic                       spiClk,
  output logic                       i2cScl,
  output logic                       spiSelect,
  output logic                       i2cAddrBit0
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [6:0] gpioS1;
  logic [6:0] gpioS2;
  logic [6:0] gpioS3;
  logic [1:0] pinS1;
  logic [1:0] pinS2;
  logic [1:0] pinS3;
  logic [6:0] gpioStable;
  logic [1:0] pinStable;

  // General-purpose pins pass three flip-flops from their pads.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gpioS1 <= pors_pkg::GPIO_RST;
      gpioS2 <= pors_pkg::GPIO_RST;
      gpioS3 <= pors_pkg::GPIO_RST;
    end else begin
      gpioS1 <= gpioIn;
      gpioS2 <= gpioS1;
      gpioS3 <= gpioS2;
    end
  end

  // The host port pins idle high, so they reset high to avoid a false edge.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinS1 <= pors_pkg::PIN_RST;
      pinS2 <= pors_pkg::PIN_RST;
      pinS3 <= pors_pkg::PIN_RST;
    end else begin
      pinS1 <= {portSelectNAddrBit0In, serialClkIn};
      pinS2 <= pinS1;
      pinS3 <= pinS2;
    end
  end

  // A level counts once the second and third stages agree.
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : gFilt
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          gpioStable[gi] <= pors_pkg::GPIO_RST[gi];
        end else if (gpioS2[gi] == gpioS3[gi]) begin
          gpioStable[gi] <= gpioS3[gi];
        end
      end
    end
    for (gi = 0; gi < 2; gi++) begin : gPinFilt
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          pinStable[gi] <= pors_pkg::PIN_RST[gi];
        end else if (pinS2[gi] == pinS3[gi]) begin
          pinStable[gi] <= pinS3[gi];
        end
      end
    end
  endgenerate

  // ****************************************
  // Sequencer
  // ****************************************
  pors_pkg::pors_state_t state;
  pors_pkg::pors_state_t next_state;
  logic [31:0]           cnt;
  wire  [31:0]           next_cnt   = cnt + 32'h0000_0001;
  wire                   windowDone = (cnt >= WINDOW_CYC - 1);
  wire                   counting   = (state == pors_pkg::PORS_WINDOW)
                                      && !windowDone;
  wire                   capture    = (state == pors_pkg::PORS_WINDOW)
                                      && windowDone;

  always_comb begin
    next_state = state;
    unique case (state)
      pors_pkg::PORS_RESET: begin
        next_state = pors_pkg::PORS_WINDOW;
      end
      pors_pkg::PORS_WINDOW: begin
        if (windowDone) begin
          next_state = pors_pkg::PORS_READY;
        end
      end
      pors_pkg::PORS_READY: begin
        next_state = pors_pkg::PORS_READY;
      end
      default: begin
        next_state = pors_pkg::PORS_RESET;
      end
    endcase
  end

  // Asynchronous reset returns everything to the reset state.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= pors_pkg::PORS_RESET;
    end else begin
      state <= next_state;
    end
  end

  // The window counter runs from entry to the window state and stops at its last count.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= pors_pkg::CNT_RST;
    end else if (counting) begin
      cnt <= next_cnt;
    end
  end

  // ****************************************
  // Strap capture and status
  // ****************************************
  // Pins 4, 5 and 6 are not sampled into the strap record.
  wire pors_pkg::pors_strap_t sampled = '{
    spiMode:   gpioStable[pors_pkg::STRAP_MODE],
    clockRate: {gpioStable[pors_pkg::STRAP_RATE1],
                gpioStable[pors_pkg::STRAP_RATE0]}
  };

  // The strap record is written once per reset, at the end of the window.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap <= pors_pkg::pors_strap_t'(pors_pkg::STRAP_RST);
    end else if (capture) begin
      strap <= sampled;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ready <= 1'h0;
    end else if (capture) begin
      ready <= 1'h1;
    end
  end

  // Only the ready bit of the status word is ever set.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      statusReg <= pors_pkg::STATUS_RST;
    end else if (capture) begin
      statusReg[pors_pkg::READY_BIT] <= 1'h1;
    end
  end

  // ****************************************
  // Pin routing
  // ****************************************
  // Pins stay released until ready, then follow their function.
  wire [6:0] next_gpioOe  = ready ? gpioFunc : pors_pkg::GPIO_RST;
  wire [6:0] next_gpioOut = ready ? (gpioOutVal & gpioFunc)
                                  : pors_pkg::GPIO_RST;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gpioOe  <= pors_pkg::GPIO_RST;
      gpioOut <= pors_pkg::GPIO_RST;
    end else begin
      gpioOe  <= next_gpioOe;
      gpioOut <= next_gpioOut;
    end
  end

  // ****************************************
  // Host port pins
  // ****************************************
  // The serial pins reach the port chosen by the mode strap only.
  wire isSpi            = ready & strap.spiMode;
  wire isI2c            = ready & ~strap.spiMode;
  wire next_spiClk      = isSpi & pinStable[0];
  wire next_i2cScl      = ~isI2c | pinStable[0];
  wire next_spiSelect   = isSpi & ~pinStable[1];
  wire next_i2cAddrBit0 = isI2c & pinStable[1];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      spiClk      <= 1'h0;
      i2cScl      <= pors_pkg::SCL_IDLE;
      spiSelect   <= 1'h0;
      i2cAddrBit0 <= 1'h0;
    end else begin
      spiClk      <= next_spiClk;
      i2cScl      <= next_i2cScl;
      spiSelect   <= next_spiSelect;
      i2cAddrBit0 <= next_i2cAddrBit0;
    end
  end

endmodule

// *** pkg/pors_pkg.sv ***
// Package for the power-on reset and strap sequencer.
package pors_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_MHZ         = 100;
  localparam int unsigned STRAP_WINDOW_MS = 125;
  localparam int unsigned STRAP_WINDOW_CYC =
    STRAP_WINDOW_MS * 1000 * CLK_MHZ;
  localparam int unsigned CNT_W = 32;
  localparam logic [31:0] CNT_RST = 32'h0000_0000;

  // ****************************************
  // Pins and reset values
  // ****************************************
  localparam int unsigned GPIO_N       = 7;
  localparam int unsigned STRAP_MODE   = 3;
  localparam int unsigned STRAP_RATE0  = 0;
  localparam int unsigned STRAP_RATE1  = 1;
  localparam int unsigned READY_BIT    = 7;
  localparam logic [7:0]  STATUS_RST   = 8'h00;
  localparam logic [6:0]  GPIO_RST     = 7'h00;
  localparam logic [1:0]  PIN_RST      = 2'h3;
  localparam logic        SCL_IDLE     = 1'h1;
  localparam logic [2:0]  STRAP_RST    = 3'h0;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    PORS_RESET  = 2'h0,
    PORS_WINDOW = 2'h1,
    PORS_READY  = 2'h2
  } pors_state_t;

  typedef struct packed {
    logic       spiMode;
    logic [1:0] clockRate;
  } pors_strap_t;

endpackage

// *** verif/pors_board.sv ***
// Board model that drives the straps after reset, then lets pulls act.
`timescale 1ns/1ps
module pors_board #(parameter int HOLD = 30) (
  input  logic       core_clk,
  input  logic       rst_n,
  input  logic [6:0] strapVal,
  input  logic [6:0] oe,
  input  logic [6:0] out,
  output logic [6:0] pins
);
  int cnt;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) cnt <= 0;
    else if (cnt < HOLD) cnt <= cnt + 1;
  end
  // Pins 5:0 pull low and pin 6 pulls high once released.
  assign pins = (oe & out) | (~oe & ((cnt < HOLD) ? strapVal : 7'h40));
endmodule

// *** verif/pors_sequencer_sva.sv ***
// Assertions for the power-on reset and strap sequencer.
`timescale 1ns/1ps
module pors_sequencer_sva (
  input logic                  core_clk,
  input logic                  rst_n,
  input logic [6:0]            gpioIn,
  input logic [6:0]            gpioFunc,
  input logic [6:0]            gpioOutVal,
  input logic                  serialClkIn,
  input logic                  portSelectNAddrBit0In,
  input logic [6:0]            gpioOut,
  input logic [6:0]            gpioOe,
  input logic [7:0]            statusReg,
  input pors_pkg::pors_strap_t strap,
  input logic                  ready,
  input logic                  spiClk,
  input logic                  i2cScl,
  input logic                  spiSelect,
  input logic                  i2cAddrBit0
);
  // ****
  // Checks
  // ****
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_rst; $rose(rst_n) |-> !ready [*8]; endproperty
  a_rst: assert property (p_rst) else $error("early ready");
  property p_st; statusReg == {ready, 7'h00}; endproperty
  a_st: assert property (p_st) else $error("status bad");
  property p_cap; $rose(ready) |-> strap == {gpioIn[3], gpioIn[1:0]};
  endproperty
  a_cap: assert property (p_cap) else $error("capture");
  property p_hold; $past(ready) |-> $stable(strap); endproperty
  a_hold: assert property (p_hold) else $error("strap moved");
  property p_oe; $past(ready) |-> gpioOe == $past(gpioFunc); endproperty
  a_oe: assert property (p_oe) else $error("oe bad");
  property p_out;
    $past(ready) |-> gpioOut == ($past(gpioOutVal) & $past(gpioFunc));
  endproperty
  a_out: assert property (p_out) else $error("out bad");
  property p_sck; !(ready && strap.spiMode) |-> !spiClk; endproperty
  a_sck: assert property (p_sck) else $error("spi clk");
  property p_scl; !(ready && !strap.spiMode) |-> i2cScl; endproperty
  a_scl: assert property (p_scl) else $error("i2c clk");
  property p_sel; spiSelect |-> ready && strap.spiMode; endproperty
  a_sel: assert property (p_sel) else $error("select");
  property p_adr; i2cAddrBit0 |-> ready && !strap.spiMode; endproperty
  a_adr: assert property (p_adr) else $error("addr bit");
  property p_sckf;
    ready && strap.spiMode && $past(ready)
      && $past(serialClkIn, 5) == $past(serialClkIn, 4)
      |-> spiClk == $past(serialClkIn, 5);
  endproperty
  a_sckf: assert property (p_sckf) else $error("spi clk lag");
  property p_adrf;
    ready && !strap.spiMode && $past(ready)
      && $past(portSelectNAddrBit0In, 5) == $past(portSelectNAddrBit0In, 4)
      |-> i2cAddrBit0 == $past(portSelectNAddrBit0In, 5);
  endproperty
  a_adrf: assert property (p_adrf) else $error("addr bit lag");
endmodule
bind pors_sequencer pors_sequencer_sva i_pors_sequencer_sva (
  .core_clk              (core_clk),
  .rst_n                 (rst_n),
  .gpioIn                (gpioIn),
  .gpioFunc              (gpioFunc),
  .gpioOutVal            (gpioOutVal),
  .serialClkIn           (serialClkIn),
  .portSelectNAddrBit0In (portSelectNAddrBit0In),
  .gpioOut               (gpioOut),
  .gpioOe                (gpioOe),
  .statusReg             (statusReg),
  .strap                 (strap),
  .ready                 (ready),
  .spiClk                (spiClk),
  .i2cScl                (i2cScl),
  .spiSelect             (spiSelect),
  .i2cAddrBit0           (i2cAddrBit0)
);

// *** verif/tb.sv ***
// Testbench for the power-on reset and strap sequencer.
`timescale 1ns/1ps
module tb;
  logic core_clk = 0, rst_n = 0, sck = 1, sel = 1;
  logic [6:0] gpioFunc = 7'h00, gpioOutVal = 7'h00, strapVal = 7'h00;
  logic [6:0] gpioIn, gpioOut, gpioOe;
  logic [7:0] statusReg;
  pors_pkg::pors_strap_t strap;
  logic ready, spiClk, i2cScl, spiSelect, i2cAddrBit0;
  int n_errors = 0, comparisons = 0, n;
  logic [6:0] pins [4] = '{7'h00, 7'h09, 7'h62, 7'h4B};
  logic [2:0] exps [4] = '{3'h0, 3'h5, 3'h2, 3'h7};
  always #5 core_clk = ~core_clk;
  pors_sequencer #(.WINDOW_CYC(20)) i_pors_sequencer (.core_clk, .rst_n,
    .gpioIn, .gpioFunc, .gpioOutVal, .serialClkIn(sck),
    .portSelectNAddrBit0In(sel), .gpioOut, .gpioOe, .statusReg, .strap,
    .ready, .spiClk, .i2cScl, .spiSelect, .i2cAddrBit0);
  pors_board i_pors_board (.core_clk, .rst_n, .strapVal, .oe(gpioOe),
    .out(gpioOut), .pins(gpioIn));
  // ****
  // Tasks
  // ****
  task check(input logic [7:0] seen, input logic [7:0] exp, input string nm);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task boot(input logic [6:0] v);
    strapVal <= v;
    rst_n <= 0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1;
    n = 0;
    do begin
      @(posedge core_clk) #1;
      n++;
    end while (ready !== 1'b1 && n < 60);
  endtask
  task finish_test();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (comparisons > 0 && n_errors == 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ****
  // Tests
  // ****
  initial begin
    #20000;
    n_errors++;
    finish_test();
  end
  initial begin
    for (int i = 0; i < 4; i++) begin
      boot(pins[i]);
      check(8'(n >= 18 && n <= 26), 8'h01, "latency");
      check(8'(strap), 8'(exps[i]), "strap");
      check(statusReg, 8'h80, "status");
    end
    @(posedge core_clk);
    strapVal <= 7'h00;
    gpioFunc <= 7'h7F;
    gpioOutVal <= 7'h55;
    sel <= 0;
    repeat (30) @(posedge core_clk);
    #1;
    check(8'(strap), 8'h07, "hold");
    check(8'(gpioOe), 8'h7F, "oe");
    check(8'(gpioOut), 8'h55, "out");
    check({spiClk, i2cScl, spiSelect, i2cAddrBit0, 4'h0}, 8'hE0, "spi");
    @(posedge core_clk);
    sck <= 0;
    sel <= 1;
    boot(7'h01);
    check(8'(strap), 8'h01, "i2c");
    repeat (8) @(posedge core_clk);
    #1;
    check({spiClk, i2cScl, spiSelect, i2cAddrBit0, 4'h0}, 8'h10, "i2cp");
    finish_test();
  end
endmodule
